// ==== cnb_pkg.sv ====
// constants and types shared by the ccm nonce builder files
package cnb_pkg;

    // widths and counts
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned PN_W    = 48;
    localparam int unsigned INST_N  = 8;
    localparam int unsigned INST_W  = 3;
    localparam int unsigned CO_N    = 4;
    localparam int unsigned SEQ_W   = 9;
    localparam int unsigned FIXID_W = 12;
    localparam int unsigned PORTABLE_MOBILITY_ID_W  = 20;
    localparam int unsigned LCN_W   = 3;
    localparam int unsigned LEN_W   = 16;
    localparam int unsigned IV_W    = 128;
    localparam int unsigned START_HI_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FIXED_ID = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PORT_ID  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_INST_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_KEY      = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_OPEN     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_START_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_START_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_PN_LO    = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_PN_HI    = 8'h24;

    // field positions
    localparam int unsigned CFG_LCN_LSB    = 3;
    localparam int unsigned CFG_DIR_BIT    = 6;
    localparam int unsigned CFG_LONG_BIT   = 7;
    localparam int unsigned KEY_DELIV_LSB  = 8;
    localparam int unsigned OPEN_GO_BIT    = 8;
    localparam int unsigned OPEN_CLOSE_BIT = 9;
    localparam int unsigned STAT_FAIL_BIT  = 8;
    localparam int unsigned STAT_REF_BIT   = 9;

    // fixed iv octets
    localparam logic [7:0] IV_FLAGS = 8'h09;
    localparam logic [7:0] IV_NRESV = 8'h00;
    localparam logic [7:0] IV_FIXED = 8'h00;
    localparam logic [3:0] IV_RSV12 = 4'h0;

    // low-bit masks of the explicit sequence number
    localparam logic [PN_W-1:0] MASK_SHORT = 48'h0000_0000_00FF;
    localparam logic [PN_W-1:0] MASK_LONG  = 48'h0000_0000_01FF;

    typedef logic [PN_W-1:0] cnb_pn_t;

    typedef struct packed {
        logic [LCN_W-1:0] link_connection_number;
        logic             dir;
        logic             long_seq;
    } cnb_cfg_t;

endpackage

// ==== cnb_pn_if.sv ====
// carrier between the builder and one packet number context
`timescale 1ns/1ns
`default_nettype none
interface cnb_pn_if;
    import cnb_pkg::*;
    logic             clear;
    cnb_pn_t          load_val;
    logic             step;
    logic [SEQ_W-1:0] seq;
    logic             long_seq;
    cnb_pn_t          pn;

    modport ctrl (output clear, output load_val, output step, output seq, output long_seq, input pn);
    modport ctx  (input clear, input load_val, input step, input seq, input long_seq, output pn);
endinterface
`default_nettype wire

// ==== cnb_pn_ctx.sv ====
// one 48-bit packet number context, extended from the link sequence number
`timescale 1ns/1ns
`default_nettype none
module cnb_pn_ctx (
    input wire logic pclk,
    input wire logic presetn,
    cnb_pn_if.ctx    pif
);
    import cnb_pkg::*;

    cnb_pn_t pn_q;
    cnb_pn_t pn_d;
    cnb_pn_t mask;
    cnb_pn_t new_low;
    cnb_pn_t prev_low;
    cnb_pn_t upper;

    // low bits from the first pdu, upper bits carried and bumped on wrap
    always_comb begin
        mask     = pif.long_seq ? MASK_LONG : MASK_SHORT;
        new_low  = PN_W'(pif.seq) & mask;
        prev_low = pn_q & mask;
        upper    = pn_q & ~mask;
        if (new_low < prev_low) begin
            upper = upper + (mask + 1'b1); // wraps mod 2^48 by width
        end
        pn_d = upper | new_low;
    end

    // clear on open wins over a step in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pn_q <= '0;
        end else if (pif.clear) begin
            pn_q <= pif.load_val;
        end else if (pif.step) begin
            pn_q <= pn_d;
        end
    end

    assign pif.pn = pn_q;

endmodule
`default_nettype wire

// ==== cnb_nonce_builder.sv ====
// ccm iv builder with per-instance packet numbers and apb registers
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - octets 8-11 hold fixed then portable identity
// - fixed identity is low 12 bits only
// - octet 8 fixed[11:4], octet 9 high nibble fixed[3:0]
// - portable identity split over octets 9 to 11
// - portable identity is 20 bits, MSB first
// - each direction has its own iv context
// - octet 12 bits 0-2 carry connection number
// - octet 12 bits 3-6 are zero
// - direction bit 0 downlink, 1 uplink
// - packet number is 48-bit unsigned
// - low bits equal first pdu sequence number
// - only 8 or 9 low bits travel
// - hidden upper bits increment on sequence wrap
// - receiver rebuilds number from previous value
// - no clear transmission, refuse without key
// - open without key fails with error
// - multicast instance is its own one-way context
// - multicast always uses long sequence frames
// - multicast sequence counters are fully independent
// - each instance selects its own key
// - multicast data waits for delivered key
// - octet 0 is constant 09 hex
// - octets 1 and 13 are zero
// - octets 14-15 carry sdu length, big endian
// - direction flag is bit 7 of octet 12
module cnb_nonce_builder (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [cnb_pkg::ADDR_W-1:0] paddr,
    input  wire logic [cnb_pkg::DATA_W-1:0] pwdata,
    output logic      [cnb_pkg::DATA_W-1:0] prdata_q,
    output logic                          pready_q,
    output logic                          pslverr_q,
    input  wire logic                     sdu_start,
    input  wire logic [cnb_pkg::INST_W-1:0] sdu_inst,
    input  wire logic [cnb_pkg::SEQ_W-1:0]  sdu_seq,
    input  wire logic [cnb_pkg::LEN_W-1:0]  sdu_len,
    output logic      [cnb_pkg::IV_W-1:0]   iv_q,
    output logic                          iv_valid_q,
    output logic      [cnb_pkg::INST_W-1:0] iv_key_slot_q,
    output logic                          sdu_refused_q,
    output logic                          setup_fail_q
);
    import cnb_pkg::*;

    // register state
    logic [FIXID_W-1:0]    fixed_id_q;
    logic [PORTABLE_MOBILITY_ID_W-1:0]     portable_mobility_id_q;
    cnb_cfg_t              cfg_q [CO_N];
    logic [INST_W-1:0]     cfg_sel_q;
    logic [INST_N-1:0]     key_valid_q;
    logic [INST_N-CO_N-1:0] key_deliv_q;
    logic [INST_N-1:0]     open_q;
    logic [DATA_W-1:0]     start_lo_q;
    logic [START_HI_W-1:0] start_hi_q;
    logic                  fail_flag_q;
    logic                  ref_flag_q;
    cnb_pn_t               last_pn_q;

    // request pipeline
    logic                  pend_q;
    logic [INST_W-1:0]     pend_inst_q;
    logic [LEN_W-1:0]      pend_len_q;

    // bus decode
    logic                  wr_en;
    logic                  setup;
    logic                  mapped;
    logic [DATA_W-1:0]     rdata_d;

    // command decode
    logic [INST_W-1:0]     open_inst;
    logic                  open_go;
    logic                  open_close;
    logic                  open_ok;
    logic                  open_bad;
    logic                  mc_req;
    logic                  req_ok;
    logic                  req_bad;

    // per-instance wiring
    cnb_pn_t               pn_all [INST_N];
    cnb_pn_t               pn_sel;
    cnb_cfg_t              cfg_sel;
    logic [IV_W-1:0]       iv_d;

    cnb_pn_if pif [INST_N] ();

    // a write takes effect at the access edge where pready is seen high
    assign wr_en = psel & penable & pwrite & pready_q;
    assign setup = psel & ~penable;

    // open / close command fields
    assign open_inst  = pwdata[INST_W-1:0];
    assign open_go    = wr_en & (paddr == OFF_OPEN) & pwdata[OPEN_GO_BIT];
    assign open_close = wr_en & (paddr == OFF_OPEN) & pwdata[OPEN_CLOSE_BIT];
    assign open_ok    = open_go & key_valid_q[open_inst];
    assign open_bad   = open_go & ~key_valid_q[open_inst];

    // sdu admission: never build a nonce for an unkeyed link
    assign mc_req  = (sdu_inst >= INST_W'(CO_N));
    assign req_ok  = sdu_start & open_q[sdu_inst] & key_valid_q[sdu_inst]
                   & (~mc_req | key_deliv_q[sdu_inst[INST_W-2:0]]);
    assign req_bad = sdu_start & ~req_ok;

    // one context per instance; directions and channels never share one
    for (genvar g = 0; g < INST_N; g++) begin : g_ctx
        cnb_pn_ctx u_ctx (
            .pclk    (pclk),
            .presetn (presetn),
            .pif     (pif[g])
        );

        assign pif[g].clear = open_ok & (open_inst == INST_W'(g));
        assign pif[g].step  = req_ok & (sdu_inst == INST_W'(g));
        assign pif[g].seq   = sdu_seq;
        assign pn_all[g]    = pif[g].pn;

        if (g < CO_N) begin : g_co
            // connection links restart the hidden count from zero
            assign pif[g].load_val = '0;
            assign pif[g].long_seq = cfg_q[g].long_seq;
        end else begin : g_mc
            // multicast may start anywhere, always 9 explicit bits
            assign pif[g].load_val = {start_hi_q, start_lo_q};
            assign pif[g].long_seq = 1'b1;
        end
    end

    assign pn_sel  = pn_all[pend_inst_q];
    assign cfg_sel = (pend_inst_q < INST_W'(CO_N)) ? cfg_q[pend_inst_q[INST_W-2:0]] : '0;

    // iv assembly, octet 0 in the top byte
    always_comb begin
        iv_d = {
            IV_FLAGS,
            IV_NRESV,
            pn_sel,
            fixed_id_q[FIXID_W-1:4],
            fixed_id_q[3:0],
            portable_mobility_id_q[PORTABLE_MOBILITY_ID_W-1:16],
            portable_mobility_id_q[15:8],
            portable_mobility_id_q[7:0],
            cfg_sel.dir,
            IV_RSV12,
            cfg_sel.link_connection_number,
            IV_FIXED,
            pend_len_q
        };
    end

    // identity registers keep only the bits the iv uses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_id_q <= '0;
            portable_mobility_id_q     <= '0;
        end else if (wr_en) begin
            if (paddr == OFF_FIXED_ID) begin
                fixed_id_q <= pwdata[FIXID_W-1:0];
            end
            if (paddr == OFF_PORT_ID) begin
                portable_mobility_id_q <= pwdata[PORTABLE_MOBILITY_ID_W-1:0];
            end
        end
    end

    // per-connection settings; multicast slots have fixed settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_sel_q <= '0;
            for (int i = 0; i < CO_N; i++) begin
                cfg_q[i] <= '0;
            end
        end else if (wr_en && paddr == OFF_INST_CFG) begin
            cfg_sel_q <= pwdata[INST_W-1:0];
            if (pwdata[INST_W-1:0] < INST_W'(CO_N)) begin
                cfg_q[pwdata[INST_W-2:0]] <= '{
                    link_connection_number:      pwdata[CFG_LCN_LSB +: LCN_W],
                    dir:      pwdata[CFG_DIR_BIT],
                    long_seq: pwdata[CFG_LONG_BIT]
                };
            end
        end
    end

    // key presence per instance; each instance is its own key slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_valid_q <= '0;
            key_deliv_q <= '0;
        end else if (wr_en && paddr == OFF_KEY) begin
            key_valid_q <= pwdata[INST_N-1:0];
            key_deliv_q <= pwdata[KEY_DELIV_LSB +: INST_N-CO_N];
        end
    end

    // multicast start value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_lo_q <= '0;
            start_hi_q <= '0;
        end else if (wr_en) begin
            if (paddr == OFF_START_LO) begin
                start_lo_q <= pwdata;
            end
            if (paddr == OFF_START_HI) begin
                start_hi_q <= pwdata[START_HI_W-1:0];
            end
        end
    end

    // open state; a keyless open leaves the instance closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_q <= '0;
        end else if (open_ok) begin
            open_q[open_inst] <= 1'b1;
        end else if (open_close) begin
            open_q[open_inst] <= 1'b0;
        end
    end

    // sticky error flags, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_flag_q <= 1'b0;
            ref_flag_q  <= 1'b0;
        end else begin
            if (open_bad) begin
                fail_flag_q <= 1'b1;
            end else if (wr_en && paddr == OFF_STATUS && pwdata[STAT_FAIL_BIT]) begin
                fail_flag_q <= 1'b0;
            end
            if (req_bad) begin
                ref_flag_q <= 1'b1;
            end else if (wr_en && paddr == OFF_STATUS && pwdata[STAT_REF_BIT]) begin
                ref_flag_q <= 1'b0;
            end
        end
    end

    // error pulses to the segmenter and call control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_fail_q  <= 1'b0;
            sdu_refused_q <= 1'b0;
        end else begin
            setup_fail_q  <= open_bad;
            sdu_refused_q <= req_bad;
        end
    end

    // stage one: the context steps, remember what to build
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q      <= 1'b0;
            pend_inst_q <= '0;
            pend_len_q  <= '0;
        end else begin
            pend_q <= req_ok;
            if (req_ok) begin
                pend_inst_q <= sdu_inst;
                pend_len_q  <= sdu_len;
            end
        end
    end

    // stage two: the stepped number is ready, present the iv
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iv_q          <= '0;
            iv_valid_q    <= 1'b0;
            iv_key_slot_q <= '0;
            last_pn_q     <= '0;
        end else begin
            iv_valid_q <= pend_q;
            if (pend_q) begin
                iv_q          <= iv_d;
                iv_key_slot_q <= pend_inst_q;
                last_pn_q     <= pn_sel;
            end
        end
    end

    // read mux and map check
    always_comb begin
        rdata_d = '0;
        mapped  = 1'b1;
        unique case (paddr)
            OFF_FIXED_ID: rdata_d[FIXID_W-1:0] = fixed_id_q;
            OFF_PORT_ID:  rdata_d[PORTABLE_MOBILITY_ID_W-1:0]  = portable_mobility_id_q;
            OFF_INST_CFG: begin
                rdata_d[INST_W-1:0] = cfg_sel_q;
                if (cfg_sel_q < INST_W'(CO_N)) begin
                    rdata_d[CFG_LCN_LSB +: LCN_W] = cfg_q[cfg_sel_q[INST_W-2:0]].link_connection_number;
                    rdata_d[CFG_DIR_BIT]          = cfg_q[cfg_sel_q[INST_W-2:0]].dir;
                    rdata_d[CFG_LONG_BIT]         = cfg_q[cfg_sel_q[INST_W-2:0]].long_seq;
                end else begin
                    rdata_d[CFG_LONG_BIT] = 1'b1;
                end
            end
            OFF_KEY: begin
                rdata_d[INST_N-1:0]                     = key_valid_q;
                rdata_d[KEY_DELIV_LSB +: INST_N-CO_N]   = key_deliv_q;
            end
            OFF_OPEN:     rdata_d[INST_N-1:0]      = open_q;
            OFF_START_LO: rdata_d                  = start_lo_q;
            OFF_START_HI: rdata_d[START_HI_W-1:0]  = start_hi_q;
            OFF_STATUS: begin
                rdata_d[INST_N-1:0]   = open_q;
                rdata_d[STAT_FAIL_BIT] = fail_flag_q;
                rdata_d[STAT_REF_BIT]  = ref_flag_q;
            end
            OFF_PN_LO:    rdata_d = last_pn_q[DATA_W-1:0];
            OFF_PN_HI:    rdata_d[PN_W-DATA_W-1:0] = last_pn_q[PN_W-1:DATA_W];
            default:      mapped  = 1'b0;
        endcase
    end

    // apb answer: one wait-free access cycle, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

endmodule
`default_nettype wire

// ==== cnb_checker.sv ====
// concurrent checks on the nonce builder ports
`timescale 1ns/1ns
`default_nettype none
module cnb_checker (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [cnb_pkg::ADDR_W-1:0]  paddr,
    input wire logic [cnb_pkg::DATA_W-1:0]  pwdata,
    input wire logic [cnb_pkg::DATA_W-1:0]  prdata_q,
    input wire logic                        pready_q,
    input wire logic                        pslverr_q,
    input wire logic                        sdu_start,
    input wire logic [cnb_pkg::INST_W-1:0]  sdu_inst,
    input wire logic [cnb_pkg::SEQ_W-1:0]   sdu_seq,
    input wire logic [cnb_pkg::LEN_W-1:0]   sdu_len,
    input wire logic [cnb_pkg::IV_W-1:0]    iv_q,
    input wire logic                        iv_valid_q,
    input wire logic [cnb_pkg::INST_W-1:0]  iv_key_slot_q,
    input wire logic                        sdu_refused_q,
    input wire logic                        setup_fail_q
);
    import cnb_pkg::*;
    // helpers, so that $past sees plain signals
    wire logic [7:0] seq_lo = sdu_seq[7:0];
    wire logic       open_wr = psel && penable && pwrite && (paddr == OFF_OPEN);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus handshake: setup, then one answer cycle only
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready_q ##1 !pready_q; endsequence
    a_apb_one_wait: assert property (s_setup |=> s_answer)
        else $error("apb answer not in first access cycle");
    a_slverr_qual: assert property (pslverr_q |-> pready_q)
        else $error("error response without ready");
    a_iv_fixed_octets: assert property (iv_valid_q |-> iv_q[127:112] == {IV_FLAGS, 8'h00} && iv_q[23:16] == 8'h00)
        else $error("constant iv octets wrong");
    a_oct12_rsv: assert property (iv_valid_q && !iv_key_slot_q[2] |-> iv_q[30:27] == 4'h0)
        else $error("reserved octet 12 bits not zero");
    a_iv_cause: assert property (iv_valid_q |-> $past(sdu_start, 2))
        else $error("iv without start two cycles before");
    a_iv_len: assert property (iv_valid_q |-> iv_q[15:0] == $past(sdu_len, 2))
        else $error("length octets differ from sdu length");
    a_pn_low: assert property (iv_valid_q |-> iv_q[71:64] == $past(seq_lo, 2))
        else $error("packet number low bits differ from sequence");
    a_key_slot: assert property (iv_valid_q |-> iv_key_slot_q == $past(sdu_inst, 2))
        else $error("key slot differs from context");
    a_mc_long: assert property (iv_valid_q && iv_key_slot_q[2] |-> iv_q[72:64] == $past(sdu_seq, 2))
        else $error("multicast not using nine sequence bits");
    a_refuse_time: assert property (sdu_refused_q |-> $past(sdu_start) ##1 !iv_valid_q)
        else $error("refusal without start or with iv");
    a_fail_time: assert property (setup_fail_q |-> $past(open_wr))
        else $error("setup failure without open write");
endmodule
`default_nettype wire

// ==== cnb_seg_model.sv ====
// segmenter and engine side model: launches sdus, collects ivs
`timescale 1ns/1ns
`default_nettype none
module cnb_seg_model (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       go,
    input  wire logic [cnb_pkg::INST_W-1:0] inst_i,
    input  wire logic [cnb_pkg::SEQ_W-1:0]  seq_i,
    input  wire logic [cnb_pkg::LEN_W-1:0]  len_i,
    output logic                            start_q,
    output logic      [cnb_pkg::INST_W-1:0] inst_q,
    output logic      [cnb_pkg::SEQ_W-1:0]  seq_q,
    output logic      [cnb_pkg::LEN_W-1:0]  len_q,
    input  wire logic                       iv_valid_q,
    input  wire logic [cnb_pkg::IV_W-1:0]   iv_q,
    input  wire logic [cnb_pkg::INST_W-1:0] iv_key_slot_q,
    input  wire logic                       sdu_refused_q,
    output logic      [cnb_pkg::IV_W-1:0]   got_iv_q,
    output logic      [cnb_pkg::INST_W-1:0] got_slot_q,
    output logic      [7:0]                 n_iv_q,
    output logic      [7:0]                 n_ref_q
);
    // lines are valid only with start; otherwise flipped so stale values never pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
            inst_q  <= '0;
            seq_q   <= '0;
            len_q   <= '0;
        end else begin
            start_q <= go;
            inst_q  <= go ? inst_i : ~inst_q;
            seq_q   <= go ? seq_i : ~seq_q;
            len_q   <= go ? len_i : ~len_q;
        end
    end
    // engine side: take iv and slot in their one valid cycle, count refusals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_iv_q   <= '0;
            got_slot_q <= '0;
            n_iv_q     <= '0;
            n_ref_q    <= '0;
        end else begin
            if (iv_valid_q) begin
                got_iv_q   <= iv_q;
                got_slot_q <= iv_key_slot_q;
                n_iv_q     <= n_iv_q + 8'h01;
            end
            if (sdu_refused_q) begin
                n_ref_q <= n_ref_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// top bench: apb and sdu stimulus against expected iv values
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cnb_pkg::*;
    logic                pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, err, go;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata_q, rd;
    logic                sdu_start, iv_valid_q, sdu_refused_q, setup_fail_q;
    logic [INST_W-1:0]   sdu_inst, iv_key_slot_q, inst_i, got_slot_q;
    logic [SEQ_W-1:0]    sdu_seq, seq_i;
    logic [LEN_W-1:0]    sdu_len, len_i;
    logic [IV_W-1:0]     iv_q, got_iv_q;
    logic [7:0]          n_iv_q, n_ref_q;
    int                  n_fail, total_checks;

    cnb_nonce_builder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .sdu_start(sdu_start), .sdu_inst(sdu_inst), .sdu_seq(sdu_seq), .sdu_len(sdu_len), .iv_q(iv_q),
        .iv_valid_q(iv_valid_q), .iv_key_slot_q(iv_key_slot_q), .sdu_refused_q(sdu_refused_q),
        .setup_fail_q(setup_fail_q));
    cnb_seg_model seg (.pclk(pclk), .presetn(presetn), .go(go), .inst_i(inst_i), .seq_i(seq_i), .len_i(len_i),
        .start_q(sdu_start), .inst_q(sdu_inst), .seq_q(sdu_seq), .len_q(sdu_len), .iv_valid_q(iv_valid_q),
        .iv_q(iv_q), .iv_key_slot_q(iv_key_slot_q), .sdu_refused_q(sdu_refused_q), .got_iv_q(got_iv_q),
        .got_slot_q(got_slot_q), .n_iv_q(n_iv_q), .n_ref_q(n_ref_q));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        rd  = prdata_q;
        err = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // identities fixed by the register setup below: fixed 0xABC, portable 0x12345
    function automatic logic [127:0] iv_exp(input logic [47:0] pn, input logic [7:0] o12, input logic [15:0] l);
        return {IV_FLAGS, 8'h00, pn, 32'hABC1_2345, o12, 8'h00, l};
    endfunction

    // launch one sdu, then check the iv or the refusal
    task automatic sdu(input logic [2:0] i, input logic [8:0] s, input logic [15:0] l, input logic ok,
                       input logic [47:0] pn, input logic [7:0] o12);
        logic [7:0] a;
        logic [7:0] b;
        a = n_iv_q;
        b = n_ref_q;
        @(posedge pclk);
        go     <= 1'b1;
        inst_i <= i;
        seq_i  <= s;
        len_i  <= l;
        @(posedge pclk);
        go <= 1'b0;
        while (n_iv_q === a && n_ref_q === b) begin
            @(posedge pclk);
        end
        if (ok) begin
            chk(got_iv_q, iv_exp(pn, o12, l));
            chk(got_slot_q, i);
        end else begin
            chk(n_ref_q, b + 8'h01);
            chk(n_iv_q, a);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, go} = 5'h0;
        {paddr, pwdata, inst_i, seq_i, len_i} = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // identities with junk above their widths, unmapped access
        apb(1'b1, OFF_FIXED_ID, 32'hFFFF_FABC);
        apb(1'b1, OFF_PORT_ID, 32'hFFF1_2345);
        apb(1'b1, OFF_INST_CFG, 32'h0000_0028);
        apb(1'b1, OFF_INST_CFG, 32'h0000_0069);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        $display("test registers done");
        // refusal before open, open without key fails
        sdu(3'd0, 9'h001, 16'h0004, 1'b0, 48'h0000, 8'h00);
        apb(1'b1, OFF_OPEN, 32'h0000_0100);
        @(posedge pclk);
        chk(setup_fail_q, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rd[9:0], 10'h300);
        $display("test refusal done");
        // keys, opens, multicast start value
        apb(1'b1, OFF_KEY, 32'h0000_0133);
        apb(1'b1, OFF_OPEN, 32'h0000_0105);
        apb(1'b1, OFF_OPEN, 32'h0000_0100);
        apb(1'b1, OFF_OPEN, 32'h0000_0101);
        apb(1'b1, OFF_START_LO, 32'h0000_01FE);
        apb(1'b1, OFF_START_HI, 32'h0000_0000);
        apb(1'b1, OFF_OPEN, 32'h0000_0104);
        apb(1'b0, OFF_OPEN, 32'h0000_0000);
        chk(rd[7:0], 8'h33);
        // downlink context with sequence wrap, then one uplink sdu on instance 1
        sdu(3'd0, 9'h0F0, 16'h0014, 1'b1, 48'h00F0, 8'h05);
        sdu(3'd0, 9'h005, 16'h0014, 1'b1, 48'h0105, 8'h05);
        sdu(3'd0, 9'h1F3, 16'hFFFF, 1'b1, 48'h01F3, 8'h05);
        sdu(3'd1, 9'h0F0, 16'h0001, 1'b1, 48'h00F0, 8'h85);
        // multicast uses nine bits, wraps at 512
        sdu(3'd4, 9'h1FF, 16'h0010, 1'b1, 48'h01FF, 8'h00);
        sdu(3'd4, 9'h003, 16'h0010, 1'b1, 48'h0203, 8'h00);
        apb(1'b0, OFF_PN_LO, 32'h0000_0000);
        chk(rd, 32'h0000_0203);
        apb(1'b0, OFF_PN_HI, 32'h0000_0000);
        chk(rd[15:0], 16'h0000);
        sdu(3'd5, 9'h010, 16'h0010, 1'b0, 48'h0000, 8'h00);
        $display("test build done");
        // close, refuse, reopen from zero
        apb(1'b1, OFF_OPEN, 32'h0000_0200);
        sdu(3'd0, 9'h010, 16'h0002, 1'b0, 48'h0000, 8'h00);
        apb(1'b1, OFF_OPEN, 32'h0000_0100);
        sdu(3'd0, 9'h010, 16'h0002, 1'b1, 48'h0010, 8'h05);
        $display("test reopen done");
        stop_test();
    end
endmodule

bind cnb_nonce_builder cnb_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .sdu_start(sdu_start), .sdu_inst(sdu_inst), .sdu_seq(sdu_seq), .sdu_len(sdu_len),
    .iv_q(iv_q), .iv_valid_q(iv_valid_q), .iv_key_slot_q(iv_key_slot_q), .sdu_refused_q(sdu_refused_q),
    .setup_fail_q(setup_fail_q));
`default_nettype wire
